// *** core/wrp_dev_end.sv ***
`timescale 1ns/100ps
`include "wrp_cfg.svh"

// Byte FIFO with a registered output stage
module wrp_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = `WRP_FIFO_DEPTH
) (
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    // Pop into the output stage whenever it is empty or being drained
    assign in_ready = (count_q != (AW+1)'(DEPTH));
    assign push     = in_valid & in_ready;
    assign pop      = (count_q != '0) & (~out_valid | out_ready);

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    // Pointers wrap at DEPTH, which need not be a power of two
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (pop) begin
            out_valid <= 1'b1;
            out_data  <= mem[rd_ptr_q];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule

module wrp_dev_end
    import wrp_pkg::*;
#(
    parameter int DEPTH = `WRP_FIFO_DEPTH
) (
    input  wire logic       sys_clk,
    input  wire logic       reset,
    wrp_link_if.dev         link,
    input  wire wrp_mode_e  mode,
    input  wire logic       gig_speed,
    input  wire logic       wan_led_select,
    input  wire logic [9:0] led_state,
    output logic [7:0]      rx_data,
    output logic            rx_error,
    output logic            rx_last,
    output logic            rx_valid,
    input  wire logic       rx_ready,
    output logic            rx_drop_q
);
    localparam int FW = `WRP_DATA_W + 2;

    logic          clk_s_q;
    logic          clk_p_q;
    logic          ctl_s_q;
    logic          er_s_q;
    logic [7:0]    d_s_q;
    logic          rise;
    logic          fall;
    logic          ddr;
    logic          rise_valid_q;
    logic [3:0]    rise_nib_q;
    logic          beat;
    logic          beat_valid;
    logic          beat_err;
    logic          beat_nib;
    logic [7:0]    beat_byte;
    logic          side_err;
    logic          half_q;
    logic [3:0]    lo_q;
    wrp_rx_state_e state_q;
    logic [1:0]    led_hold_q;
    logic          led_blank;
    logic          frame_err_q;
    logic          pend_q;
    logic [7:0]    pend_byte_q;
    logic          byte_rdy;
    logic [7:0]    new_byte;
    logic          push;
    logic [FW-1:0] push_word;
    logic          fifo_ready;
    logic [FW-1:0] fifo_word;

    // Pin samples; the link clock is just another sampled level
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            clk_s_q <= 1'b0;
            clk_p_q <= 1'b0;
            ctl_s_q <= 1'b0;
            er_s_q  <= 1'b0;
            d_s_q   <= 8'h00;
        end else begin
            clk_s_q <= link.rx_clk;
            clk_p_q <= clk_s_q;
            ctl_s_q <= link.valid_pin;
            er_s_q  <= link.error_pin;
            d_s_q   <= link.data_pin;
        end
    end

    assign rise = clk_s_q & ~clk_p_q;
    assign fall = ~clk_s_q & clk_p_q;
    assign ddr  = (mode == WRP_RGMII) & gig_speed;

    // LED levels linger on the pins two cycles after select drops
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            led_hold_q <= 2'h0;
        end else begin
            led_hold_q <= {led_hold_q[0], wan_led_select};
        end
    end

    assign led_blank = wan_led_select | (|led_hold_q);

    // Rising-edge half of an RGMII beat
    always_ff @(posedge sys_clk) begin
        if (reset || led_blank) begin
            rise_valid_q <= 1'b0;
            rise_nib_q   <= 4'h0;
        end else if (rise) begin
            rise_valid_q <= ctl_s_q;
            rise_nib_q   <= d_s_q[3:0];
        end
    end

    // Decode one receive beat per mode
    always_comb begin
        beat       = 1'b0;
        beat_valid = ctl_s_q;
        beat_err   = 1'b0;
        beat_nib   = 1'b1;
        beat_byte  = {4'h0, d_s_q[3:0]};
        side_err   = 1'b0;
        case (mode)
            WRP_GMII: begin
                beat      = rise;
                beat_err  = er_s_q;
                beat_nib  = 1'b0;
                beat_byte = d_s_q;
            end
            WRP_MII, WRP_TURBO_MII: begin
                beat     = rise;
                beat_err = er_s_q;
            end
            WRP_RGMII: begin
                side_err = fall & (ctl_s_q ^ rise_valid_q);
                if (ddr) begin
                    beat       = fall;
                    beat_valid = rise_valid_q;
                    beat_nib   = 1'b0;
                    beat_byte  = {d_s_q[3:0], rise_nib_q};
                end else begin
                    beat = rise;
                end
            end
            WRP_REV_MII, WRP_REV_TURBO: begin
                beat = rise;
            end
            default: begin
                beat = 1'b0;
            end
        endcase
    end

    // Nibble pairing, low nibble first; an odd nibble is dropped
    assign byte_rdy = beat & beat_valid & (~beat_nib | half_q);
    assign new_byte = beat_nib ? {beat_byte[3:0], lo_q} : beat_byte;

    always_ff @(posedge sys_clk) begin
        if (reset || led_blank || (beat && !beat_valid)) begin
            half_q <= 1'b0;
            lo_q   <= 4'h0;
        end else if (beat && beat_nib) begin
            half_q <= ~half_q;
            lo_q   <= half_q ? lo_q : beat_byte[3:0];
        end
    end

    // Frame tracking; one byte held back so the last can be marked
    always_ff @(posedge sys_clk) begin
        if (reset || led_blank) begin
            state_q     <= WRP_RX_IDLE;
            frame_err_q <= 1'b0;
            pend_q      <= 1'b0;
            pend_byte_q <= 8'h00;
        end else begin
            if (beat && beat_valid) begin
                state_q <= WRP_RX_FRAME;
            end else if (beat) begin
                state_q <= WRP_RX_IDLE;
            end
            if (beat && !beat_valid) begin
                frame_err_q <= 1'b0;
            end else if ((beat && beat_valid && beat_err) || side_err) begin
                frame_err_q <= 1'b1;
            end
            if (byte_rdy) begin
                pend_q      <= 1'b1;
                pend_byte_q <= new_byte;
            end else if (beat && !beat_valid) begin
                pend_q <= 1'b0;
            end
        end
    end

    // Push the held byte; close the frame when valid drops
    always_comb begin
        push      = 1'b0;
        push_word = {1'b0, 1'b0, pend_byte_q};
        if (!led_blank && pend_q) begin
            if (byte_rdy) begin
                push = 1'b1;
            end else if (beat && !beat_valid
                         && state_q == WRP_RX_FRAME) begin
                push      = 1'b1;
                push_word = {1'b1, frame_err_q, pend_byte_q};
            end
        end
    end

    // The link cannot be stalled, so a full FIFO drops and reports it
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rx_drop_q <= 1'b0;
        end else begin
            rx_drop_q <= push & ~fifo_ready;
        end
    end

    wrp_fifo #(
        .WIDTH (FW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .in_valid  (push),
        .in_data   (push_word),
        .in_ready  (fifo_ready),
        .out_valid (rx_valid),
        .out_data  (fifo_word),
        .out_ready (rx_ready)
    );

    assign rx_data  = fifo_word[7:0];
    assign rx_error = fifo_word[8];
    assign rx_last  = fifo_word[9];

    // Pin personality: WAN input or LED driver
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            link.dev_oe    <= 1'b0;
            link.dev_valid <= 1'b0;
            link.dev_error <= 1'b0;
            link.dev_data  <= 8'h00;
        end else begin
            link.dev_oe    <= wan_led_select;
            link.dev_valid <= led_state[`WRP_LED_VALID_BIT];
            link.dev_error <= led_state[`WRP_LED_ERROR_BIT];
            link.dev_data  <= led_state[7:0];
        end
    end
endmodule

// *** core/wrp_cfg.svh ***
`ifndef WRP_CFG_SVH
`define WRP_CFG_SVH

// System clock rate
`define WRP_SYS_CLK_KHZ      200000

// Receive clock rates supplied by the far end, in kHz
`define WRP_RXCLK_1000_KHZ   125000
`define WRP_RXCLK_100_KHZ    25000
`define WRP_RXCLK_10_KHZ     2500
`define WRP_RXCLK_TURBO_KHZ  50000

// Half period of the receive clock in system cycles, rounded down but never below one
`define WRP_HALF_CYC(f) \
    ((`WRP_SYS_CLK_KHZ / (2 * (f))) < 1 ? 1 : (`WRP_SYS_CLK_KHZ / (2 * (f))))
`define WRP_HALF_1000        `WRP_HALF_CYC(`WRP_RXCLK_1000_KHZ)
`define WRP_HALF_100         `WRP_HALF_CYC(`WRP_RXCLK_100_KHZ)
`define WRP_HALF_10          `WRP_HALF_CYC(`WRP_RXCLK_10_KHZ)
`define WRP_HALF_TURBO       `WRP_HALF_CYC(`WRP_RXCLK_TURBO_KHZ)
`define WRP_DIV_W            8

// Link speed codes
`define WRP_SPEED_10         2'h0
`define WRP_SPEED_100        2'h1
`define WRP_SPEED_1000       2'h2

// LED numbering: pin LED index minus this base
`define WRP_LED_BASE         10
`define WRP_LED_VALID_BIT    8
`define WRP_LED_ERROR_BIT    9

// Default FIFO shape
`define WRP_FIFO_DEPTH       16
`define WRP_DATA_W           8

`endif

// *** core/wrp_pkg.sv ***
package wrp_pkg;

    // Interface personality of the WAN receive pins
    typedef enum logic [2:0] {
        WRP_GMII      = 3'b000,
        WRP_MII       = 3'b001,
        WRP_TURBO_MII = 3'b010,
        WRP_RGMII     = 3'b011,
        WRP_REV_MII   = 3'b100,
        WRP_REV_TURBO = 3'b101
    } wrp_mode_e;

    // Far end beat sequencing
    typedef enum logic [1:0] {
        WRP_FE_TAKE = 2'b00,
        WRP_FE_HIGH = 2'b01,
        WRP_FE_GAP  = 2'b10
    } wrp_fe_state_e;

    // Device frame tracking
    typedef enum logic [0:0] {
        WRP_RX_IDLE  = 1'b0,
        WRP_RX_FRAME = 1'b1
    } wrp_rx_state_e;

endpackage

// *** core/wrp_link_if.sv ***
`timescale 1ns/100ps

interface wrp_link_if;
    logic       rx_clk;
    logic       fe_valid;
    logic       fe_error;
    logic [7:0] fe_data;
    logic       fe_oe;
    logic       dev_valid;
    logic       dev_error;
    logic [7:0] dev_data;
    logic       dev_oe;
    logic       valid_pin;
    logic       error_pin;
    logic [7:0] data_pin;

    // Pin levels; pull-down when nobody drives, device wins a clash
    assign valid_pin = dev_oe ? dev_valid : (fe_oe & fe_valid);
    assign error_pin = dev_oe ? dev_error : (fe_oe & fe_error);
    assign data_pin  = dev_oe ? dev_data : (fe_oe ? fe_data : 8'h00);

    modport dev (
        input  rx_clk,
        input  valid_pin,
        input  error_pin,
        input  data_pin,
        output dev_valid,
        output dev_error,
        output dev_data,
        output dev_oe
    );

    modport far (
        output rx_clk,
        output fe_valid,
        output fe_error,
        output fe_data,
        output fe_oe,
        input  valid_pin,
        input  error_pin,
        input  data_pin
    );
endinterface

// *** core/wrp_far_end.sv ***
`timescale 1ns/100ps
`include "wrp_cfg.svh"

module wrp_far_end
    import wrp_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset,
    wrp_link_if.far         link,
    input  wire wrp_mode_e  mode,
    input  wire logic [1:0] speed,
    input  wire logic       wan_led_select,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_error,
    input  wire logic       tx_last,
    output logic            tx_ready_q
);
    localparam int DW = `WRP_DIV_W;

    logic [DW-1:0] div_q;
    logic [DW-1:0] half;
    logic          clk_q;
    logic          toggle;
    logic          beat_rise;
    logic          beat_fall;
    logic          ddr;
    logic          nib_mode;
    logic          uses_er;
    logic          buf_full_q;
    logic [7:0]    buf_data_q;
    logic          buf_err_q;
    logic          buf_last_q;
    logic          accept;
    logic          consume;
    logic [7:0]    cur_q;
    logic          cur_err_q;
    logic          cur_last_q;
    wrp_fe_state_e state_q;

    // Clock rate by mode and speed
    always_comb begin
        if (mode == WRP_TURBO_MII || mode == WRP_REV_TURBO) begin
            half = DW'(`WRP_HALF_TURBO);
        end else if (speed == `WRP_SPEED_1000) begin
            half = DW'(`WRP_HALF_1000);
        end else if (speed == `WRP_SPEED_100) begin
            half = DW'(`WRP_HALF_100);
        end else begin
            half = DW'(`WRP_HALF_10);
        end
    end

    assign toggle    = (div_q >= half - 1'b1);
    assign beat_rise = toggle & ~clk_q;
    assign beat_fall = toggle & clk_q;
    assign ddr       = (mode == WRP_RGMII) && (speed == `WRP_SPEED_1000);
    assign nib_mode  = (mode != WRP_GMII) && !ddr;
    assign uses_er   = (mode == WRP_GMII) || (mode == WRP_MII)
                       || (mode == WRP_TURBO_MII);

    // Divider makes the receive clock from the system clock
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            div_q <= '0;
            clk_q <= 1'b0;
        end else if (toggle) begin
            div_q <= '0;
            clk_q <= ~clk_q;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // One-byte holding buffer toward the user
    assign accept  = tx_valid & tx_ready_q;
    assign consume = beat_rise & (state_q == WRP_FE_TAKE) & buf_full_q
                     & ~wan_led_select;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            buf_full_q <= 1'b0;
            buf_data_q <= 8'h00;
            buf_err_q  <= 1'b0;
            buf_last_q <= 1'b0;
            tx_ready_q <= 1'b0;
        end else begin
            if (accept) begin
                buf_full_q <= 1'b1;
                buf_data_q <= tx_data;
                buf_err_q  <= tx_error;
                buf_last_q <= tx_last;
            end else if (consume) begin
                buf_full_q <= 1'b0;
            end
            tx_ready_q <= ~((buf_full_q & ~consume) | accept);
        end
    end

    // Beat sequencing; outputs change together with the clock edge
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_q       <= WRP_FE_TAKE;
            cur_q         <= 8'h00;
            cur_err_q     <= 1'b0;
            cur_last_q    <= 1'b0;
            link.rx_clk   <= 1'b0;
            link.fe_oe    <= 1'b0;
            link.fe_valid <= 1'b0;
            link.fe_error <= 1'b0;
            link.fe_data  <= 8'h00;
        end else begin
            link.rx_clk <= toggle ? ~clk_q : clk_q;
            link.fe_oe  <= ~wan_led_select;
            if (beat_rise) begin
                case (state_q)
                    WRP_FE_TAKE: begin
                        link.fe_valid <= consume;
                        link.fe_error <= consume & buf_err_q & uses_er;
                        link.fe_data  <= (mode == WRP_GMII) ? buf_data_q
                                         : {4'h0, buf_data_q[3:0]};
                        if (consume) begin
                            cur_q      <= buf_data_q;
                            cur_err_q  <= buf_err_q;
                            cur_last_q <= buf_last_q;
                            if (nib_mode) begin
                                state_q <= WRP_FE_HIGH;
                            end else if (buf_last_q) begin
                                state_q <= WRP_FE_GAP;
                            end
                        end
                    end
                    WRP_FE_HIGH: begin
                        link.fe_valid <= 1'b1;
                        link.fe_error <= cur_err_q & uses_er;
                        link.fe_data  <= {4'h0, cur_q[7:4]};
                        state_q <= cur_last_q ? WRP_FE_GAP : WRP_FE_TAKE;
                    end
                    WRP_FE_GAP: begin
                        link.fe_valid <= 1'b0;
                        link.fe_error <= 1'b0;
                        state_q       <= WRP_FE_TAKE;
                    end
                    default: begin
                        state_q <= WRP_FE_TAKE;
                    end
                endcase
            end else if (beat_fall && mode == WRP_RGMII) begin
                link.fe_valid <= link.fe_valid ^ (link.fe_valid & cur_err_q);
                if (ddr) begin
                    link.fe_data <= {4'h0, cur_q[7:4]};
                end
            end
        end
    end
endmodule

// *** bench/wrp_link_asserts.sv ***
`timescale 1ns/100ps

// Pin-level checks between the far end and the device across the link
module wrp_link_asserts
    import wrp_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       reset,
    input wire wrp_mode_e  mode,
    input wire logic       wan_led_select,
    input wire logic [9:0] led_state,
    input wire logic       rx_clk,
    input wire logic       fe_valid,
    input wire logic       fe_error,
    input wire logic [7:0] fe_data,
    input wire logic       fe_oe,
    input wire logic       dev_valid,
    input wire logic       dev_error,
    input wire logic [7:0] dev_data,
    input wire logic       dev_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // LED outputs follow the select and state one cycle behind
    a_led_valid_map: assert property (
        wan_led_select && !$past(reset)
        |=> dev_oe && dev_valid == $past(led_state[8]))
        else $error("valid pin is not LED 18");
    a_led_error_map: assert property (
        wan_led_select && !$past(reset)
        |=> dev_oe && dev_error == $past(led_state[9]))
        else $error("error pin is not LED 19");
    a_led_data_map: assert property (
        wan_led_select && !$past(reset)
        |=> dev_oe && dev_data == $past(led_state[7:0]))
        else $error("data pins are not LEDs 10 to 17");
    a_dev_quiet_wan: assert property (
        !$past(wan_led_select) && !$past(reset) |-> !dev_oe)
        else $error("device drives the pins in WAN mode");
    // Far end must leave the pins alone while they serve as LEDs
    a_far_quiet_led: assert property (
        wan_led_select && $past(wan_led_select) && $past(wan_led_select, 2)
        |-> !fe_oe)
        else $error("far end drives the pins in LED mode");
    // Valid moves only with a rising receive clock outside RGMII
    a_valid_on_rise: assert property (
        mode != WRP_RGMII && mode == $past(mode) && fe_oe && $past(fe_oe)
        && fe_valid != $past(fe_valid) |-> $rose(rx_clk))
        else $error("valid changed away from a rising edge");
    a_data_on_rise: assert property (
        mode != WRP_RGMII && mode == $past(mode) && fe_oe && $past(fe_oe)
        && fe_data != $past(fe_data) |-> $rose(rx_clk))
        else $error("data changed away from a rising edge");
    a_rgmii_data_edge: assert property (
        mode == WRP_RGMII && mode == $past(mode) && fe_oe && $past(fe_oe)
        && fe_data != $past(fe_data) |-> rx_clk != $past(rx_clk))
        else $error("RGMII data changed away from a clock edge");
    // Idle rise gives an idle fall: valid xor error stays low
    a_rgmii_fall_ctl: assert property (
        mode == WRP_RGMII && fe_oe && $past(fe_oe) && $fell(rx_clk)
        && !$past(fe_valid) |-> !fe_valid)
        else $error("RGMII fall control high outside a frame");
    a_error_in_frame: assert property (
        mode inside {WRP_GMII, WRP_MII, WRP_TURBO_MII} && fe_oe && fe_error
        |-> fe_valid)
        else $error("error line raised outside a frame");
endmodule

// *** bench/test_wan_port_receive_pin_interface.sv ***
`timescale 1ns/100ps
`include "wrp_cfg.svh"

`define WRP_CHECK(what, exp, got) \
    begin \
        compares++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got); \
        end \
    end

module test_wan_port_receive_pin_interface
    import wrp_pkg::*;
;
    logic       sys_clk = 1'b0;
    logic       reset = 1'b1;
    wrp_mode_e  mode = WRP_GMII;
    logic [1:0] speed = 2'h2;
    logic       wan_led_select = 1'b0;
    logic [9:0] led_state = 10'h000;
    logic       tx_valid = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic       tx_error = 1'b0;
    logic       tx_last = 1'b0;
    logic       tx_ready_q;
    logic [7:0] rx_data;
    logic       rx_error;
    logic       rx_last;
    logic       rx_valid;
    logic       rx_ready = 1'b1;
    logic       rx_drop_q;
    logic       stall = 1'b0;
    logic       drop_seen = 1'b0;
    logic       clk_prev = 1'b0;
    logic       valid_prev = 1'b0;
    logic [9:0] rxq[$];
    logic [9:0] expq[$];
    int         mismatches = 0;
    int         compares = 0;
    int         cyc_q = 0;
    int         period_q = 0;
    wrp_mode_e  modes[9] = '{WRP_GMII, WRP_MII, WRP_MII, WRP_TURBO_MII,
        WRP_RGMII, WRP_RGMII, WRP_RGMII, WRP_REV_MII, WRP_REV_TURBO};
    logic [1:0] speeds[9] = '{2'h2, 2'h1, 2'h0, 2'h1, 2'h2, 2'h1, 2'h0,
        2'h1, 2'h1};

    wrp_link_if link ();

    wrp_far_end u_wrp_far_end (
        .sys_clk       (sys_clk),
        .reset         (reset),
        .link          (link.far),
        .mode          (mode),
        .speed         (speed),
        .wan_led_select(wan_led_select),
        .tx_valid      (tx_valid),
        .tx_data       (tx_data),
        .tx_error      (tx_error),
        .tx_last       (tx_last),
        .tx_ready_q    (tx_ready_q)
    );

    wrp_dev_end #(.DEPTH(16)) u_wrp_dev_end (
        .sys_clk       (sys_clk),
        .reset         (reset),
        .link          (link.dev),
        .mode          (mode),
        .gig_speed     (speed == 2'h2),
        .wan_led_select(wan_led_select),
        .led_state     (led_state),
        .rx_data       (rx_data),
        .rx_error      (rx_error),
        .rx_last       (rx_last),
        .rx_valid      (rx_valid),
        .rx_ready      (rx_ready),
        .rx_drop_q     (rx_drop_q)
    );

    wrp_link_asserts u_wrp_link_asserts (
        .sys_clk(sys_clk), .reset(reset), .mode(mode),
        .wan_led_select(wan_led_select), .led_state(led_state),
        .rx_clk(link.rx_clk), .fe_valid(link.fe_valid),
        .fe_error(link.fe_error), .fe_data(link.fe_data),
        .fe_oe(link.fe_oe), .dev_valid(link.dev_valid),
        .dev_error(link.dev_error), .dev_data(link.dev_data),
        .dev_oe(link.dev_oe)
    );

    always #2.5 sys_clk = ~sys_clk;

    // Random back-pressure keeps the FIFO output stage busy
    always @(negedge sys_clk) begin
        rx_ready <= stall ? 1'b0 : 1'($urandom_range(1));
    end

    // Word collector and receive clock period meter inside frames
    always @(posedge sys_clk) begin
        if (!reset && rx_valid === 1'b1 && rx_ready)
            rxq.push_back({rx_error, rx_last, rx_data});
        if (!reset && rx_drop_q === 1'b1)
            drop_seen = 1'b1;
        cyc_q++;
        if (link.rx_clk && !clk_prev) begin
            if (link.valid_pin && valid_prev)
                period_q = cyc_q;
            cyc_q = 0;
            valid_prev = link.valid_pin;
        end
        clk_prev = link.rx_clk;
    end

    function automatic int exp_period(wrp_mode_e m, logic [1:0] s);
        if (m == WRP_TURBO_MII || m == WRP_REV_TURBO)
            return 2 * `WRP_HALF_TURBO;
        if (m == WRP_GMII || s == `WRP_SPEED_1000)
            return 2 * `WRP_HALF_1000;
        return (s == `WRP_SPEED_100) ? 2 * `WRP_HALF_100 : 2 * `WRP_HALF_10;
    endfunction

    // Reverse modes have no error path on the wire
    function automatic logic carries_error(wrp_mode_e m);
        return m inside {WRP_GMII, WRP_MII, WRP_TURBO_MII, WRP_RGMII};
    endfunction

    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Error goes on the first byte; the device must keep it to the end
    task automatic send_frame(int len, logic err);
        logic [7:0] d;
        int         n;
        @(negedge sys_clk);
        for (int i = 0; i < len; i++) begin
            d = 8'($urandom);
            tx_valid = 1'b1;
            tx_data = d;
            tx_last = (i == len - 1);
            tx_error = err && (i == 0);
            expq.push_back({err && carries_error(mode) && (i == len - 1),
                (i == len - 1), d});
            n = 0;
            @(posedge sys_clk);
            while (tx_ready_q !== 1'b1) begin
                n++;
                if (n > 2000) begin
                    mismatches++;
                    $display("[FAIL] tx_ready_q expected 1 seen timeout");
                    conclude();
                end
                @(posedge sys_clk);
            end
            @(negedge sys_clk);
        end
        tx_valid = 1'b0;
    endtask

    task automatic wait_rx(int count);
        int n;
        n = 0;
        while (rxq.size() < count) begin
            n++;
            if (n > 5000) begin
                mismatches++;
                $display("[FAIL] rx words expected %0d seen timeout", count);
                conclude();
            end
            @(negedge sys_clk);
        end
        repeat (200) @(negedge sys_clk);
    endtask

    task automatic check_rx();
        wait_rx(expq.size());
        foreach (expq[i]) `WRP_CHECK("rx word", expq[i], rxq[i])
        `WRP_CHECK("rx count", expq.size(), rxq.size())
        expq.delete();
        rxq.delete();
    endtask

    initial begin
        void'($urandom(52723));
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        reset = 1'b0;
        repeat (2) @(negedge sys_clk);
        // Every personality: one-byte error frame, then a random one
        foreach (modes[i]) begin
            mode = modes[i];
            speed = speeds[i];
            repeat (200) @(negedge sys_clk);
            send_frame(1, 1'b1);
            send_frame(2 + $urandom_range(6), 1'($urandom_range(1)));
            check_rx();
            `WRP_CHECK("rx_clk period", exp_period(mode, speed), period_q)
            $display("Test mode %0d speed %0d done", mode, speed);
        end
        // Overflow: the link cannot stall, so words are dropped
        mode = WRP_GMII;
        speed = 2'h2;
        stall = 1'b1;
        repeat (20) @(negedge sys_clk);
        send_frame(20, 1'b0);
        repeat (40) @(negedge sys_clk);
        `WRP_CHECK("drop pulse", 1'b1, drop_seen)
        stall = 1'b0;
        repeat (100) @(negedge sys_clk);
        `WRP_CHECK("fill level", 1'b1, rxq.size() inside {16, 17})
        foreach (rxq[i]) `WRP_CHECK("kept byte", expq[i][7:0], rxq[i][7:0])
        `WRP_CHECK("drained", 1'b0, rx_valid)
        expq.delete();
        rxq.delete();
        $display("Test overflow done");
        // LED personality of the pins
        wan_led_select = 1'b1;
        repeat (3) @(negedge sys_clk);
        repeat (8) begin
            led_state = 10'($urandom);
            repeat (2) @(negedge sys_clk);
            `WRP_CHECK("led 18", led_state[8], link.valid_pin)
            `WRP_CHECK("led 19", led_state[9], link.error_pin)
            `WRP_CHECK("led 10-17", led_state[7:0], link.data_pin)
        end
        `WRP_CHECK("led rx words", 0, rxq.size())
        wan_led_select = 1'b0;
        repeat (20) @(negedge sys_clk);
        send_frame(3, 1'b0);
        check_rx();
        $display("Test led select done");
        conclude();
    end
endmodule
